// ==== hw/bmlc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmlc_top #(
    parameter int unsigned MS_CYC = bmlc_pkg::MS_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        common_button_i,
    input  wire logic        reverse_store_button_i,
    input  wire logic        middle_store_button_i,
    input  wire logic        forward_store_button_i,
    input  wire logic        ext_fwd_i,
    input  wire logic        ext_back_i,
    input  wire logic        move_fwd_i,
    input  wire logic        move_mid_i,
    input  wire logic        move_rev_i,
    input  wire logic        limit_fwd_i,
    input  wire logic        limit_mid_i,
    input  wire logic        limit_rev_i,
    input  wire logic        encoder_channel_a_i,
    input  wire logic        encoder_channel_b_i,
    output logic             motor_fwd_o,
    output logic             motor_rev_o,
    output logic             led_green_o,
    output logic             restart_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [11:0] raw;
    logic [11:0] db;
    assign raw = {move_rev_i, move_mid_i, move_fwd_i, ext_back_i, ext_fwd_i,
                  limit_rev_i, limit_mid_i, limit_fwd_i,
                  reverse_store_button_i, middle_store_button_i,
                  forward_store_button_i, common_button_i};
    genvar d;
    generate
        for (d = 0; d < 12; d++)
        begin : g_deb
            bmlc_debounce u_deb (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .ce_i    (ce_i),
                .raw_i   (raw[d]),
                .level_o (db[d])
            );
        end
    endgenerate

    wire       common_db = db[0];
    wire [2:0] st_btn    = db[3:1];
    wire       lim_fwd   = db[4];
    wire       lim_mid   = db[5];
    wire       lim_rev   = db[6];
    wire       ext_fwd   = db[7];
    wire       ext_back  = db[8];
    wire [2:0] mv_btn    = db[11:9];

    bmlc_pkg::bmlc_cfg_s cfg;
    bmlc_pkg::bmlc_mot_e st;
    bmlc_pkg::bmlc_mot_e next_st;
    bmlc_pkg::bmlc_tgt_e tgt;
    bmlc_pkg::bmlc_tgt_e next_tgt;
    bmlc_pkg::bmlc_fr_e  fr_st;
    bmlc_pkg::bmlc_fr_e  next_fr;
    logic                dir_fwd;
    logic                next_dir;
    logic [19:0]         tmo;
    logic [19:0]         run_ms;
    logic                tmo_flag;
    logic [15:0]         pre;
    logic [12:0]         fr_ms;
    logic [2:0]          mv_prev;
    logic signed [31:0]  enc_pos;
    logic signed [31:0]  pos_set [3];
    logic [2:0]          stored;
    logic [2:0]          store_pulse;
    logic [2:0]          held_done;
    logic                enc_a;
    logic                enc_b;
    logic                enc_a_p;
    logic                enc_b_p;

    wire ms_tick = pre == 16'(MS_CYC - 1);
    wire fr_run  = fr_st == bmlc_pkg::FR_RUN;
    wire dual    = cfg.enc == bmlc_pkg::ENC_DUAL;
    wire toggle  = !cfg.mid_conn && !dual && cfg.semi && cfg.mid_func;
    wire [2:0] mv_rise = mv_btn & ~mv_prev;

    wire at_fwd = lim_fwd | (dual & stored[0] & (enc_pos >= pos_set[0]));
    wire at_rev = lim_rev | (dual & stored[2] & (enc_pos <= pos_set[2]));
    wire at_mid = (cfg.mid_conn & lim_mid) | (dual & stored[1] &
                  (dir_fwd ? enc_pos >= pos_set[1] : enc_pos <= pos_set[1]));

    wire man_fwd = ext_fwd | (common_db & st_btn[0]);
    wire man_rev = ext_back | (common_db & st_btn[2]);

    // middle start from an end limit, or from a stored middle position with dual encoder
    wire mid_from_lim = lim_fwd | lim_rev;
    wire mid_cmp_ok   = dual & stored[1] & (enc_pos != pos_set[1]);
    wire mid_ok       = cfg.mid_func & (mid_cmp_ok | mid_from_lim);
    wire mid_dir      = mid_cmp_ok ? (pos_set[1] > enc_pos) : lim_rev;
    wire bmlc_pkg::bmlc_tgt_e mid_tgt = !toggle ? bmlc_pkg::TG_MID :
                                        lim_rev ? bmlc_pkg::TG_FWD :
                                                  bmlc_pkg::TG_REV;

    wire auto_req = cfg.semi & (mv_rise[0] | mv_rise[2] |
                                (mv_rise[1] & mid_ok));
    wire auto_dir = mv_rise[0] ? 1'b1 : mv_rise[2] ? 1'b0 : mid_dir;
    wire bmlc_pkg::bmlc_tgt_e auto_tgt = mv_rise[0] ? bmlc_pkg::TG_FWD :
                                         mv_rise[2] ? bmlc_pkg::TG_REV :
                                                      mid_tgt;
    wire auto_ok  = auto_dir ? !at_fwd : !at_rev;
    wire mid_stop = mv_rise[1] & !cfg.mid_func;
    wire tmo_hit  = (tmo != 20'h00000) && (run_ms >= tmo);
    wire end_hit  = dir_fwd ? at_fwd : at_rev;
    wire reached  = (tgt == bmlc_pkg::TG_MID) ? at_mid : end_hit;
    wire man_end  = dir_fwd ? (!man_fwd | at_fwd) : (!man_rev | at_rev);

    always_comb
    begin
        next_st  = st;
        next_dir = dir_fwd;
        next_tgt = tgt;
        case (st)
            bmlc_pkg::MS_IDLE:
            begin
                if (!fr_run)
                    next_st = bmlc_pkg::MS_IDLE;
                else if (man_fwd && !at_fwd && !tmo_flag)
                begin
                    next_st  = bmlc_pkg::MS_MANUAL;
                    next_dir = 1'b1;
                end
                else if (man_rev && !at_rev && !tmo_flag)
                begin
                    next_st  = bmlc_pkg::MS_MANUAL;
                    next_dir = 1'b0;
                end
                else if (auto_req && auto_ok)
                begin
                    next_st  = bmlc_pkg::MS_AUTO;
                    next_dir = auto_dir;
                    next_tgt = auto_tgt;
                end
            end
            bmlc_pkg::MS_MANUAL:
                if (man_end || tmo_hit)
                    next_st = bmlc_pkg::MS_IDLE;
            bmlc_pkg::MS_AUTO:
                if (reached || end_hit || tmo_hit || mid_stop)
                    next_st = bmlc_pkg::MS_IDLE;
            default:
                next_st = bmlc_pkg::MS_IDLE;
        endcase
    end

    wire fact_done = (fr_st == bmlc_pkg::FR_HEART) &&
                     (fr_ms >= bmlc_pkg::HEART_MS);

    always_comb
    begin
        next_fr = fr_st;
        case (fr_st)
            bmlc_pkg::FR_BOOT:
                if (common_db)
                    next_fr = bmlc_pkg::FR_BLINK;
                else if (fr_ms >= bmlc_pkg::BOOT_MS)
                    next_fr = bmlc_pkg::FR_RUN;
            bmlc_pkg::FR_BLINK:
                if (!common_db)
                    next_fr = bmlc_pkg::FR_RUN;
                else if (fr_ms >= bmlc_pkg::FACT_HOLD_MS)
                    next_fr = bmlc_pkg::FR_STEADY;
            bmlc_pkg::FR_STEADY:
                if (!common_db)
                    next_fr = bmlc_pkg::FR_HEART;
            bmlc_pkg::FR_HEART:
                if (fact_done)
                    next_fr = bmlc_pkg::FR_RUN;
            bmlc_pkg::FR_RUN:
                next_fr = bmlc_pkg::FR_RUN;
            default:
                next_fr = bmlc_pkg::FR_RUN;
        endcase
    end

    localparam int unsigned BLINK_LOW = bmlc_pkg::BLINK_BIT;
    wire heart_on = (fr_ms[9:8] == 2'h0) & ~fr_ms[BLINK_LOW];
    wire next_led = (next_fr == bmlc_pkg::FR_BLINK)  ? fr_ms[BLINK_LOW] :
                    (next_fr == bmlc_pkg::FR_STEADY) ? 1'b1 :
                    (next_fr == bmlc_pkg::FR_HEART)  ? heart_on :
                    (next_fr == bmlc_pkg::FR_RUN)    ?
                    ((|stored) & ~(|(held_done & st_btn))) : 1'b0;

    genvar k;
    generate
        for (k = 0; k < 3; k++)
        begin : g_store
            logic [12:0] hold_ms;
            wire pressing = st_btn[k] & ~common_db & dual & fr_run;
            assign held_done[k]   = hold_ms == bmlc_pkg::STORE_HOLD_MS;
            assign store_pulse[k] = pressing & ms_tick &
                (hold_ms == bmlc_pkg::STORE_HOLD_MS - 13'h0001);
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    hold_ms <= 13'h0000;
                else if (ce_i)
                begin
                    if (!pressing && !st_btn[k])
                        hold_ms <= 13'h0000;
                    else if (pressing && ms_tick && !held_done[k])
                        hold_ms <= hold_ms + 13'h0001;
                end
            end
        end
    endgenerate

    // APB decode
    wire       acc    = psel_i & penable_i & pready_o;
    wire       wr_en  = acc & pwrite_i;
    wire       sel_ctrl = paddr_i == bmlc_pkg::ADDR_CTRL;
    wire       sel_tmo  = paddr_i == bmlc_pkg::ADDR_TMO;
    wire       sel_stat = paddr_i == bmlc_pkg::ADDR_STAT;
    wire       sel_enc  = paddr_i == bmlc_pkg::ADDR_ENC;
    wire [2:0] sel_pos  = {paddr_i == bmlc_pkg::ADDR_POS_REV,
                           paddr_i == bmlc_pkg::ADDR_POS_MID,
                           paddr_i == bmlc_pkg::ADDR_POS_FWD};
    wire       mapped = sel_ctrl | sel_tmo | sel_stat | sel_enc | (|sel_pos);
    wire [31:0] stat_word = {21'h000000, fr_st, st == bmlc_pkg::MS_AUTO,
                             tmo_flag, toggle, stored,
                             motor_rev_o, motor_fwd_o};
    wire [31:0] rd_word = sel_ctrl   ? {27'h0000000, cfg} :
                          sel_tmo    ? {12'h000, tmo} :
                          sel_pos[0] ? pos_set[0] :
                          sel_pos[1] ? pos_set[1] :
                          sel_pos[2] ? pos_set[2] :
                          sel_stat   ? stat_word :
                          sel_enc    ? enc_pos : 32'h00000000;
    wire enc_step = enc_a ^ enc_a_p ^ enc_b ^ enc_b_p;
    wire enc_up   = enc_a_p ^ enc_b;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else if (ce_i)
        begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            prdata_o  <= rd_word;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && fact_done))
        begin
            cfg <= bmlc_pkg::bmlc_cfg_s'(bmlc_pkg::CTRL_RST);
            tmo <= bmlc_pkg::TMO_RST;
        end
        else if (ce_i && wr_en && sel_ctrl)
            cfg <= bmlc_pkg::bmlc_cfg_s'(pwdata_i[4:0]);
        else if (ce_i && wr_en && sel_tmo)
            tmo <= pwdata_i[19:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stored <= 3'h0;
            for (int i = 0; i < 3; i++)
                pos_set[i] <= bmlc_pkg::POS_RST;
        end
        else if (ce_i)
        begin
            for (int i = 0; i < 3; i++)
                if (fact_done)
                begin
                    pos_set[i] <= bmlc_pkg::POS_RST;
                    stored[i]  <= 1'b0;
                end
                else if (store_pulse[i])
                begin
                    pos_set[i] <= enc_pos;
                    stored[i]  <= 1'b1;
                end
                else if (wr_en && sel_pos[i] && dual)
                begin
                    pos_set[i] <= pwdata_i;
                    stored[i]  <= 1'b1;
                end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= bmlc_pkg::MS_IDLE;
            tgt <= bmlc_pkg::TG_FWD;
            dir_fwd <= 1'b0;
            motor_fwd_o <= 1'b0;
            motor_rev_o <= 1'b0;
            fr_st <= bmlc_pkg::FR_BOOT;
            fr_ms <= 13'h0000;
            led_green_o <= 1'b0;
            restart_o <= 1'b0;
            pre <= 16'h0000;
            run_ms <= 20'h00000;
            tmo_flag <= 1'b0;
            mv_prev <= 3'h0;
            enc_a <= 1'b0;
            enc_b <= 1'b0;
            enc_a_p <= 1'b0;
            enc_b_p <= 1'b0;
            enc_pos <= 32'sh00000000;
        end
        else if (ce_i)
        begin
            st <= next_st;
            tgt <= next_tgt;
            dir_fwd <= next_dir;
            motor_fwd_o <= (next_st != bmlc_pkg::MS_IDLE) & next_dir;
            motor_rev_o <= (next_st != bmlc_pkg::MS_IDLE) & ~next_dir;
            fr_st <= next_fr;
            fr_ms <= (next_fr != fr_st) ? 13'h0000 :
                     fr_ms + {12'h000, ms_tick};
            led_green_o <= next_led;
            restart_o <= fact_done;
            pre <= ms_tick ? 16'h0000 : pre + 16'h0001;
            run_ms <= (st == bmlc_pkg::MS_IDLE) ? 20'h00000 :
                      run_ms + {19'h00000, ms_tick};
            tmo_flag <= tmo_hit | (tmo_flag & (man_fwd | man_rev) &
                        ~(st == bmlc_pkg::MS_IDLE & auto_req));
            mv_prev <= mv_btn;
            enc_a <= encoder_channel_a_i;
            enc_b <= encoder_channel_b_i;
            enc_a_p <= enc_a;
            enc_b_p <= enc_b;
            if (enc_step)
                enc_pos <= enc_up ? enc_pos + 32'sh00000001 :
                                    enc_pos - 32'sh00000001;
        end
    end

    chk_dir_exclusive: assert property (!(motor_fwd_o && motor_rev_o))
        else $error("motor driven both ways");
    chk_fwd_limit: assert property (ce_i && at_fwd |=> !motor_fwd_o)
        else $error("forward drive at forward limit");
    chk_rev_limit: assert property (ce_i && at_rev |=> !motor_rev_o)
        else $error("reverse drive at reverse limit");
    chk_combo_fwd: assert property (
        ce_i && st == bmlc_pkg::MS_IDLE && fr_run && common_db && st_btn[0]
        && !at_fwd && !tmo_flag |=> motor_fwd_o)
        else $error("common plus forward store did not drive");
    chk_store_capture: assert property (
        ce_i && store_pulse[0] |=> pos_set[0] == $past(enc_pos) && stored[0])
        else $error("store did not capture position");
    chk_store_dual: assert property (
        ce_i && !dual && fr_run |=> $stable(stored))
        else $error("stored flags changed without dual encoder");
    chk_auto_runs: assert property (
        ce_i && st == bmlc_pkg::MS_AUTO && !reached && !end_hit && !tmo_hit
        && !mid_stop |=> st == bmlc_pkg::MS_AUTO && $stable(dir_fwd))
        else $error("auto move ended early");
    chk_steady_led: assert property (
        ce_i && fr_st == bmlc_pkg::FR_STEADY && common_db |=> led_green_o)
        else $error("steady indicator not lit");
    chk_factory_restart: assert property (
        ce_i && fact_done |=> restart_o && fr_run && stored == 3'h0
        && cfg == bmlc_pkg::bmlc_cfg_s'(bmlc_pkg::CTRL_RST))
        else $error("factory restore incomplete");
    chk_timeout_stop: assert property (
        ce_i && tmo_hit && st != bmlc_pkg::MS_IDLE
        |=> st == bmlc_pkg::MS_IDLE && !motor_fwd_o && !motor_rev_o)
        else $error("timeout did not stop motor");
endmodule
`default_nettype wire

// ==== hw/bmlc_pkg.sv ====
package bmlc_pkg;
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned MS_CYC      = CLK_HZ / 1000;
    localparam int unsigned DEB_TIME_US = 5;
    localparam int unsigned DEB_CYC     = DEB_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [7:0]  DEB_LAST    = 8'(DEB_CYC - 1);
    localparam int unsigned STORE_HOLD_S = 5;
    localparam logic [12:0] STORE_HOLD_MS = 13'(STORE_HOLD_S * 1000);
    localparam logic [12:0] FACT_HOLD_MS  = 13'h0BB8;
    localparam logic [12:0] HEART_MS      = 13'h07D0;
    localparam logic [12:0] BOOT_MS       = 13'h0032;
    localparam int unsigned BLINK_BIT     = 6;

    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TMO     = 8'h04;
    localparam logic [7:0] ADDR_POS_FWD = 8'h08;
    localparam logic [7:0] ADDR_POS_MID = 8'h0C;
    localparam logic [7:0] ADDR_POS_REV = 8'h10;
    localparam logic [7:0] ADDR_STAT    = 8'h14;
    localparam logic [7:0] ADDR_ENC     = 8'h18;

    localparam logic [4:0]  CTRL_RST = 5'h14;
    localparam logic [19:0] TMO_RST  = 20'h00000;
    localparam logic [31:0] POS_RST  = 32'h00000000;

    typedef enum logic [1:0] {
        ENC_NONE   = 2'h0,
        ENC_SINGLE = 2'h1,
        ENC_DUAL   = 2'h2
    } bmlc_enc_e;

    // Packed to match control register bits 4..0
    typedef struct packed {
        logic      mid_conn;
        logic      mid_func;
        bmlc_enc_e enc;
        logic      semi;
    } bmlc_cfg_s;

    typedef enum logic [1:0] {
        MS_IDLE   = 2'b00,
        MS_MANUAL = 2'b01,
        MS_AUTO   = 2'b11
    } bmlc_mot_e;

    typedef enum logic [1:0] {
        TG_FWD = 2'h0,
        TG_MID = 2'h1,
        TG_REV = 2'h2
    } bmlc_tgt_e;

    typedef enum logic [2:0] {
        FR_BOOT   = 3'b000,
        FR_BLINK  = 3'b001,
        FR_STEADY = 3'b011,
        FR_HEART  = 3'b010,
        FR_RUN    = 3'b110
    } bmlc_fr_e;
endpackage

// ==== hw/bmlc_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmlc_debounce (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic raw_i,
    output logic      level_o
);
    logic       sync_a;
    logic       sync_b;
    logic [7:0] cnt;
    wire        differ = sync_b ^ level_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a  <= 1'b0;
            sync_b  <= 1'b0;
            cnt     <= 8'h00;
            level_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sync_a <= raw_i;
            sync_b <= sync_a;
            if (!differ)
                cnt <= 8'h00;
            else if (cnt == bmlc_pkg::DEB_LAST)
            begin
                cnt     <= 8'h00;
                level_o <= sync_b;
            end
            else
                cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== bench/bmlc_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmlc_partner #(
    parameter int SPAN = 600
) (
    input  wire logic clk_i,
    input  wire logic motor_fwd_i,
    input  wire logic motor_rev_i,
    input  wire logic mid_conn_i,
    output logic      limit_fwd_o,
    output logic      limit_mid_o,
    output logic      limit_rev_o,
    output logic      enc_a_o,
    output logic      enc_b_o
);
    logic [15:0] pos = 16'(SPAN / 2);

    // One step per cycle; the mechanical stops hold the carriage
    always @(posedge clk_i)
    begin
        if (motor_fwd_i && pos < 16'(SPAN))
            pos <= pos + 16'h0001;
        else if (motor_rev_i && pos > 16'h0000)
            pos <= pos - 16'h0001;
    end

    assign limit_fwd_o = (pos >= 16'(SPAN));
    assign limit_rev_o = (pos == 16'h0000);
    // Middle cam stays made over a stretch; unconnected reads open
    assign limit_mid_o = mid_conn_i && (pos >= 16'(SPAN / 2)) &&
                         (pos <= 16'(SPAN * 14 / 15));
    // Gray-coded channels follow the position
    assign enc_a_o     = pos[1];
    assign enc_b_o     = pos[1] ^ pos[0];
endmodule
`default_nettype wire

// ==== bench/bmlc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmlc_top_tb;
    localparam int MSC = 5;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o, rd, rnd;
    logic        pready_o, pslverr_o, err;
    logic        cmn = 1'b0, rv_b = 1'b0, md_b = 1'b0, fw_b = 1'b0;
    logic        ext_f = 1'b0, ext_b = 1'b0, ce = 1'b1;
    logic        mv_f = 1'b0, mv_m = 1'b0, mv_r = 1'b0, mid_conn = 1'b1;
    logic        lim_f, lim_m, lim_r, enc_a, enc_b, mot_f, mot_r, led, rsto;
    int          error_cnt = 0, tests_run = 0, cyc_cnt = 0, n, tm;

    bmlc_top #(.MS_CYC(MSC)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .common_button_i(cmn), .reverse_store_button_i(rv_b),
        .middle_store_button_i(md_b), .forward_store_button_i(fw_b),
        .ext_fwd_i(ext_f), .ext_back_i(ext_b), .move_fwd_i(mv_f),
        .move_mid_i(mv_m), .move_rev_i(mv_r), .limit_fwd_i(lim_f),
        .limit_mid_i(lim_m), .limit_rev_i(lim_r),
        .encoder_channel_a_i(enc_a), .encoder_channel_b_i(enc_b),
        .motor_fwd_o(mot_f), .motor_rev_o(mot_r),
        .led_green_o(led), .restart_o(rsto)
    );

    bmlc_partner PARTNER (
        .clk_i(clk_i), .motor_fwd_i(mot_f), .motor_rev_i(mot_r),
        .mid_conn_i(mid_conn), .limit_fwd_o(lim_f), .limit_mid_o(lim_m),
        .limit_rev_o(lim_r), .enc_a_o(enc_a), .enc_b_o(enc_b)
    );

    always #12.5 clk_i = ~clk_i;

    function automatic logic [31:0] ctrl(input logic s, input logic [1:0] e,
                                         input logic f, input logic c);
        ctrl = {27'h0000000, c, f, e, s};
    endfunction

    function automatic logic [31:0] in_win(input int cyc, input int ms);
        in_win = {31'h0, (cyc >= (ms - 1) * MSC) && (cyc <= (ms + 1) * MSC + 4)};
    endfunction

    task automatic summarize;
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t %s", $time, msg);
            error_cnt++;
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && k < 20)
        begin
            @(posedge clk_i);
            k++;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, k < 20}, 32'h00000001, "apb ready missing");
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h00000000);
        chk(rd & m, exp, msg);
    endtask

    task automatic wait_mot(input logic [1:0] exp, input int lim);
        int k;
        k = 0;
        while ({mot_f, mot_r} !== exp && k < lim)
        begin
            @(posedge clk_i);
            k++;
        end
        chk({30'h0, mot_f, mot_r}, {30'h0, exp}, "motor state");
    endtask

    task automatic leds(input int len, output int ch);
        logic p;
        ch = 0;
        p = led;
        repeat (len)
        begin
            @(posedge clk_i);
            if (led !== p)
                ch++;
            p = led;
        end
    endtask

    always @(posedge clk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000)
        begin
            error_cnt++;
            summarize();
        end
    end

    initial
    begin
        rnd = $urandom(32'h1869);
        cyc(6);
        rst_i <= 1'b0;
        cyc(300);
        rdchk(bmlc_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000014, "ctrl reset");
        apb(1'b0, 8'h1C, 32'h00000000);
        chk({31'h0, err}, 32'h00000001, "unmapped no error");
        ext_f <= 1'b1;
        wait_mot(2'b10, 300);
        wait_mot(2'b00, 600);
        chk({31'h0, lim_f}, 32'h00000001, "manual stop off limit");
        ext_f <= 1'b0;
        cmn <= 1'b1;
        rv_b <= 1'b1;
        wait_mot(2'b01, 300);
        cmn <= 1'b0;
        rv_b <= 1'b0;
        wait_mot(2'b00, 300);
        cmn <= 1'b1;
        fw_b <= 1'b1;
        wait_mot(2'b10, 300);
        cmn <= 1'b0;
        fw_b <= 1'b0;
        wait_mot(2'b00, 300);
        apb(1'b1, bmlc_pkg::ADDR_CTRL, ctrl(1'b1, 2'h0, 1'b0, 1'b1));
        mv_r <= 1'b1;
        wait_mot(2'b01, 300);
        mv_r <= 1'b0;
        cyc(250);
        chk({31'h0, mot_r}, 32'h00000001, "semi run dropped");
        wait_mot(2'b00, 900);
        chk({31'h0, lim_r}, 32'h00000001, "semi stop off limit");
        apb(1'b1, bmlc_pkg::ADDR_CTRL, ctrl(1'b1, 2'h0, 1'b1, 1'b1));
        rdchk(bmlc_pkg::ADDR_STAT, 32'h00000020, 32'h0, "toggle with mid");
        mv_m <= 1'b1;
        wait_mot(2'b10, 300);
        mv_m <= 1'b0;
        wait_mot(2'b00, 600);
        chk({31'h0, lim_m}, 32'h00000001, "mid stop off switch");
        mv_m <= 1'b1;
        cyc(400);
        mv_m <= 1'b0;
        chk({30'h0, mot_f, mot_r}, 32'h0, "mid without end limit");
        ce <= 1'b0;
        ext_f <= 1'b1;
        cyc(400);
        chk({30'h0, mot_f, mot_r}, 32'h0, "ran while disabled");
        ext_f <= 1'b0;
        ce <= 1'b1;
        mid_conn <= 1'b0;
        apb(1'b1, bmlc_pkg::ADDR_CTRL, ctrl(1'b1, 2'h1, 1'b1, 1'b0));
        rdchk(bmlc_pkg::ADDR_STAT, 32'h00000020, 32'h20, "toggle off");
        ext_f <= 1'b1;
        wait_mot(2'b10, 300);
        wait_mot(2'b00, 600);
        ext_f <= 1'b0;
        cyc(300);
        mv_m <= 1'b1;
        wait_mot(2'b01, 300);
        mv_m <= 1'b0;
        wait_mot(2'b00, 900);
        chk({31'h0, lim_r}, 32'h00000001, "toggle end");
        tm = 20 + int'($urandom % 20);
        apb(1'b1, bmlc_pkg::ADDR_TMO, 32'(tm));
        mv_f <= 1'b1;
        wait_mot(2'b10, 300);
        mv_f <= 1'b0;
        n = 0;
        while (mot_f === 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(in_win(n, tm), 32'h00000001, "timeout length");
        ext_f <= 1'b1;
        wait_mot(2'b10, 300);
        wait_mot(2'b00, 300);
        cyc(20);
        rdchk(bmlc_pkg::ADDR_STAT, 32'h00000040, 32'h40, "timeout flag");
        chk({30'h0, mot_f, mot_r}, 32'h0, "restart after timeout");
        ext_f <= 1'b0;
        apb(1'b1, bmlc_pkg::ADDR_TMO, 32'h00000000);
        apb(1'b1, bmlc_pkg::ADDR_POS_FWD, $urandom);
        rdchk(bmlc_pkg::ADDR_STAT, 32'h0000001C, 32'h0, "stored w/o dual");
        apb(1'b1, bmlc_pkg::ADDR_CTRL, ctrl(1'b0, 2'h2, 1'b0, 1'b1));
        fw_b <= 1'b1;
        cyc(24000);
        rdchk(bmlc_pkg::ADDR_STAT, 32'h00000004, 32'h0, "stored early");
        cyc(1600);
        rdchk(bmlc_pkg::ADDR_STAT, 32'h00000004, 32'h4, "not stored");
        apb(1'b0, bmlc_pkg::ADDR_ENC, 32'h00000000);
        rnd = rd;
        rdchk(bmlc_pkg::ADDR_POS_FWD, 32'hFFFFFFFF, rnd, "stored pos");
        fw_b <= 1'b0;
        cyc(300);
        chk({31'h0, led}, 32'h00000001, "led after store");
        rnd = $urandom;
        apb(1'b1, bmlc_pkg::ADDR_POS_MID, rnd);
        rdchk(bmlc_pkg::ADDR_POS_MID, 32'hFFFFFFFF, rnd, "dual pos write");
        cmn <= 1'b1;
        rst_i <= 1'b1;
        cyc(6);
        rst_i <= 1'b0;
        cyc(600);
        leds(4000, n);
        chk({31'h0, n >= 4}, 32'h00000001, "no fast blink");
        cyc(11000);
        leds(400, n);
        chk({31'h0, n == 0 && led === 1'b1}, 32'h1, "not steady");
        apb(1'b1, bmlc_pkg::ADDR_POS_FWD, rnd);
        apb(1'b1, bmlc_pkg::ADDR_CTRL, ctrl(1'b1, 2'h1, 1'b1, 1'b0));
        cmn <= 1'b0;
        n = 0;
        while (rsto !== 1'b1 && n < 12000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, rsto}, 32'h00000001, "no restart");
        cyc(300);
        rdchk(bmlc_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h14, "ctrl default");
        rdchk(bmlc_pkg::ADDR_STAT, 32'h0000071C, 32'h600, "not running");
        summarize();
    end
endmodule
`default_nettype wire
